// File: rtl/pm_cap_params.svh
// constants of the power management capability registers
// included by the register module
`ifndef PM_CAP_PARAMS_SVH
`define PM_CAP_PARAMS_SVH
`define PM_OFS_CAP_WORD 8'hdc
`define PM_OFS_CTRL 8'he0
`define PM_OFS_NEXT_HDR 8'he4
`define PM_CAP_ID_PM 8'h01
`define PM_CAP_NEXT_PM 8'he4
`define PM_REV_POS 16
`define PM_REV_VALUE 3'h1
`define PM_STATE_RESET 2'h0
`define PM_NEXT_ID 8'h04
`define PM_NEXT_END 8'h00
`define PM_RESET_CYCLES 4'h4
`endif

// File: rtl/pm_cap_pkg.sv
// types of the power management capability registers
// no dependencies
package pm_cap_pkg;
   typedef enum logic [1:0] {
      FULL_ON = 2'b00,
      LIGHT_SLEEP = 2'b01,
      MEDIUM_SLEEP = 2'b10,
      DEEP_OFF = 2'b11
   } power_state_t;
endpackage

// File: rtl/power_mgmt_capability_regs.sv
// power management capability registers of a two-port bus bridge
// assumes a one-cycle register port on the primary clock, synchronous reset
//
// Function
// - revision field reads fixed 001
// - wake clock and wake support read zero
// - auxiliary power bit reads zero
// - device specific initialization bit reads zero
// - light and medium sleep support read zero
// - two-bit power state, reset to full on
// - unimplemented state writes are discarded
// - deep off to full on pulses internal reset
// - wake enable bit reads zero
// - data select and data scale read zero
// - wake status bit reads zero
// - following header carries fixed capability identifier
// - next pointer of last header reads zero
// - power capability identifier reads 01h
//
// Our own choice: strobed register access.
`include "pm_cap_params.svh"
`timescale 1ns/10ps
`default_nettype none
module power_mgmt_capability_regs (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WRITE,
   input wire logic READ,
   output logic [31:0] RDATA,
   output logic CHIP_RESET,
   output logic [1:0] POWER_STATE
);
   typedef struct packed {
      pm_cap_pkg::power_state_t state;
      logic [31:0] rdata;
      logic [3:0] rst_count;
      logic chip_reset;
   } regs_t;

   regs_t r;
   regs_t next_r;
   logic [31:0] read_word;
   logic [1:0] wr_state;
   logic wr_legal;

   // capability word fields, msb first
   localparam logic [4:0] WAKE_SUPPORT = 5'h00;
   localparam logic MEDIUM_SUPPORT = 1'b0;
   localparam logic LIGHT_SUPPORT = 1'b0;
   localparam logic [2:0] CAP_RSVD = 3'h0;
   localparam logic DEV_INIT = 1'b0;
   localparam logic AUX_POWER = 1'b0;
   localparam logic WAKE_CLOCK = 1'b0;
   // no power event pin, so every wake feature reads zero
   localparam logic [31:0] CAP_WORD = {WAKE_SUPPORT, MEDIUM_SUPPORT,
      LIGHT_SUPPORT, CAP_RSVD, DEV_INIT, AUX_POWER, WAKE_CLOCK,
      `PM_REV_VALUE, `PM_CAP_NEXT_PM, `PM_CAP_ID_PM};

   // control word fields above the state, msb first
   localparam logic WAKE_STATUS = 1'b0;
   localparam logic [1:0] DATA_SCALE = 2'h0;
   localparam logic [3:0] DATA_SELECT = 4'h0;
   localparam logic WAKE_ENABLE = 1'b0;
   localparam logic [5:0] CTRL_RSVD = 6'h00;

   always_comb begin
      read_word = 32'h0000_0000;
      if (ADDR == `PM_OFS_CAP_WORD) begin
         read_word = CAP_WORD;
      end else if (ADDR == `PM_OFS_CTRL) begin
         // upper bits are wake and data fields, none implemented
         read_word = {16'h0000, WAKE_STATUS, DATA_SCALE, DATA_SELECT,
            WAKE_ENABLE, CTRL_RSVD, r.state};
      end else if (ADDR == `PM_OFS_NEXT_HDR) begin
         read_word = {16'h0000, `PM_NEXT_END, `PM_NEXT_ID};
      end
   end

   assign wr_state = WDATA[1:0];
   // only full on and deep off exist
   assign wr_legal = (wr_state == 2'b00) || (wr_state == 2'b11);

   always_comb begin
      next_r = r;
      next_r.rdata = READ ? read_word : 32'h0000_0000;
      // count down first so that a new wake restarts the pulse
      if (r.rst_count != 4'h0) begin
         next_r.rst_count = r.rst_count - 4'h1;
      end
      if (WRITE && ADDR == `PM_OFS_CTRL && wr_legal) begin
         next_r.state = pm_cap_pkg::power_state_t'(wr_state);
         if (r.state == pm_cap_pkg::DEEP_OFF &&
             wr_state == 2'b00) begin
            next_r.rst_count = `PM_RESET_CYCLES;
         end
      end
      next_r.chip_reset = (next_r.rst_count != 4'h0);
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         r.state <= pm_cap_pkg::FULL_ON;
         r.rdata <= 32'h0000_0000;
         r.rst_count <= 4'h0;
         r.chip_reset <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign RDATA = r.rdata;
   assign CHIP_RESET = r.chip_reset;
   assign POWER_STATE = r.state;

   // checks
   a_state_legal: assert property (@(posedge CLK_SYS) disable iff (RESET)
      POWER_STATE != 2'b01 && POWER_STATE != 2'b10)
      else $error("illegal power state held");

   a_bad_write_kept: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (WRITE && ADDR == `PM_OFS_CTRL && !wr_legal) |=>
      $stable(POWER_STATE))
      else $error("unimplemented state accepted");

   a_state_write: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (WRITE && ADDR == `PM_OFS_CTRL && wr_legal) |=>
      POWER_STATE == $past(WDATA[1:0]))
      else $error("power state not written");

   a_state_hold: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !(WRITE && ADDR == `PM_OFS_CTRL && wr_legal) |=>
      $stable(POWER_STATE))
      else $error("power state changed without write");

   a_reads_no_state: assert property (@(posedge CLK_SYS) disable iff (RESET)
      READ |=>
      $stable(POWER_STATE))
      else $error("read changed power state");

   a_other_write_kept: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (WRITE && ADDR != `PM_OFS_CTRL) |=>
      $stable(POWER_STATE))
      else $error("write elsewhere changed power state");

   a_reset_state: assert property (@(posedge CLK_SYS)
      RESET |=> POWER_STATE == 2'b00)
      else $error("power state not cleared by reset");

   a_reset_rdata: assert property (@(posedge CLK_SYS)
      RESET |=> RDATA == 32'h0000_0000)
      else $error("read data not cleared by reset");

   a_reset_chip: assert property (@(posedge CLK_SYS)
      RESET |=> !CHIP_RESET)
      else $error("internal reset high after reset");

   a_wake_up_reset: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (WRITE && ADDR == `PM_OFS_CTRL && WDATA[1:0] == 2'b00 &&
      POWER_STATE == 2'b11) |=> CHIP_RESET [*4] ##1 !CHIP_RESET)
      else $error("internal reset pulse wrong");

   a_no_spurious_rst: assert property (@(posedge CLK_SYS) disable iff (RESET)
      $rose(CHIP_RESET) |-> $past(POWER_STATE) == 2'b11)
      else $error("internal reset without wake");

   a_pulse_tracks: assert property (@(posedge CLK_SYS) disable iff (RESET)
      CHIP_RESET == (r.rst_count != 4'h0))
      else $error("internal reset apart from its count");

   a_count_bound: assert property (@(posedge CLK_SYS) disable iff (RESET)
      r.rst_count <= `PM_RESET_CYCLES)
      else $error("reset count out of range");

   a_wake_rearm: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (WRITE && ADDR == `PM_OFS_CTRL && WDATA[1:0] == 2'b00 &&
      POWER_STATE == 2'b11) |=> r.rst_count == `PM_RESET_CYCLES)
      else $error("wake did not restart reset count");

   a_same_state_quiet: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (WRITE && ADDR == `PM_OFS_CTRL && POWER_STATE == 2'b00 &&
      !CHIP_RESET) |=> !CHIP_RESET)
      else $error("internal reset without deep off");

   a_cap_word_read: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CAP_WORD) |=>
      RDATA == 32'h0001_e401)
      else $error("capability word wrong");

   a_rev_field: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CAP_WORD) |=>
      RDATA[18:16] == `PM_REV_VALUE)
      else $error("revision field wrong");

   a_wake_clk_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CAP_WORD) |=>
      !RDATA[19])
      else $error("wake clock bit set");

   a_wake_sup_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CAP_WORD) |=>
      RDATA[31:27] == 5'h00)
      else $error("wake support field set");

   a_aux_pwr_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CAP_WORD) |=>
      !RDATA[20])
      else $error("auxiliary power bit set");

   a_dev_init_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CAP_WORD) |=>
      !RDATA[21])
      else $error("device init bit set");

   a_light_sup_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CAP_WORD) |=>
      !RDATA[25])
      else $error("light sleep support set");

   a_medium_sup_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CAP_WORD) |=>
      !RDATA[26])
      else $error("medium sleep support set");

   a_cap_rsvd_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CAP_WORD) |=>
      RDATA[24:22] == 3'h0)
      else $error("capability reserved bits set");

   a_pm_id_read: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CAP_WORD) |=>
      RDATA[7:0] == `PM_CAP_ID_PM)
      else $error("power capability identifier wrong");

   a_ctrl_read: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CTRL) |=>
      RDATA[31:2] == 30'h0000_0000 && RDATA[1:0] == POWER_STATE)
      else $error("control word read wrong");

   a_wake_en_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CTRL) |=>
      !RDATA[8])
      else $error("wake enable bit set");

   a_data_sel_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CTRL) |=>
      RDATA[12:9] == 4'h0)
      else $error("data select field set");

   a_data_scale_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CTRL) |=>
      RDATA[14:13] == 2'h0)
      else $error("data scale field set");

   a_wake_sts_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_CTRL) |=>
      !RDATA[15])
      else $error("wake status bit set");

   // each bit above the state on its own, so one stuck bit is named
   for (genvar b = 2; b < 32; b++) begin : g_ctrl_zero
      a_ctrl_bit_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
         (READ && ADDR == `PM_OFS_CTRL) |=>
         !RDATA[b])
         else $error("control word upper bit set");
   end

   a_next_hdr_read: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_NEXT_HDR) |=>
      RDATA == 32'h0000_0004)
      else $error("next header read wrong");

   a_next_id_read: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_NEXT_HDR) |=>
      RDATA[7:0] == `PM_NEXT_ID)
      else $error("following identifier wrong");

   a_next_end_read: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR == `PM_OFS_NEXT_HDR) |=>
      RDATA[15:8] == `PM_NEXT_END)
      else $error("list does not end");

   a_unmapped_read: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (READ && ADDR != `PM_OFS_CAP_WORD && ADDR != `PM_OFS_CTRL &&
      ADDR != `PM_OFS_NEXT_HDR) |=> RDATA == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_idle_rdata: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !READ |=>
      RDATA == 32'h0000_0000)
      else $error("read data outside read cycle");

   c_deep_off: cover property (@(posedge CLK_SYS) disable iff (RESET)
      POWER_STATE == 2'b11);

   c_wake: cover property (@(posedge CLK_SYS) disable iff (RESET)
      $rose(CHIP_RESET));

   c_bad_write: cover property (@(posedge CLK_SYS) disable iff (RESET)
      WRITE && ADDR == `PM_OFS_CTRL && WDATA[1:0] == 2'b01);

   c_back_to_back: cover property (@(posedge CLK_SYS) disable iff (RESET)
      READ ##1 READ);

   c_write_read: cover property (@(posedge CLK_SYS) disable iff (RESET)
      (WRITE && ADDR == `PM_OFS_CTRL) ##1 (READ && ADDR == `PM_OFS_CTRL));
endmodule
`default_nettype wire

// File: sim/tb.sv
// self-checking bench of the power management capability registers
// assumes the register module alone, driven through its one-cycle port
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic write = 1'b0;
   logic read = 1'b0;
   logic [31:0] rdata;
   logic chip_reset;
   logic [1:0] power_state;
   int err_count = 0;
   int checks_done = 0;
   always #12.5 clk_sys = ~clk_sys;
   power_mgmt_capability_regs dut_u (.CLK_SYS(clk_sys), .RESET(reset),
      .ADDR(addr), .WDATA(wdata), .WRITE(write), .READ(read), .RDATA(rdata),
      .CHIP_RESET(chip_reset), .POWER_STATE(power_state));
   task chk(input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   // strobes move just after an edge, one cycle wide
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      write <= 1'b1;
      @(posedge clk_sys);
      write <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      addr <= a;
      read <= 1'b1;
      @(posedge clk_sys);
      read <= 1'b0;
      #1;
      chk(exp, rdata);
   endtask
   task test_reset_values;
      rd_chk(8'hdc, 32'h0001_e401);
      rd_chk(8'he0, 32'h0000_0000);
      rd_chk(8'he4, 32'h0000_0004);
      chk(32'h0000_0000, {30'h0000_0000, power_state});
   endtask
   task test_state_writes;
      wr(8'he0, 32'hffff_ffff);
      rd_chk(8'he0, 32'h0000_0003);
      wr(8'he0, 32'h0000_0001);
      wr(8'he0, 32'h0000_0002);
      rd_chk(8'he0, 32'h0000_0003);
      wr(8'hdc, 32'h0000_0000);
      rd_chk(8'hdc, 32'h0001_e401);
      rd_chk(8'h40, 32'h0000_0000);
   endtask
   // deep off back to full on: four-cycle internal reset pulse
   task test_wake_reset;
      wr(8'he0, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         chk(32'h0000_0001, {31'h0000_0000, chip_reset});
         @(posedge clk_sys);
         #1;
      end
      chk(32'h0000_0000, {31'h0000_0000, chip_reset});
      chk(32'h0000_0000, {30'h0000_0000, power_state});
      wr(8'he0, 32'h0000_0000);
      chk(32'h0000_0000, {31'h0000_0000, chip_reset});
   endtask
   // reset in mid-run returns the state to full on
   task test_mid_reset;
      wr(8'he0, 32'h0000_0003);
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      chk(32'h0000_0000, {30'h0000_0000, power_state});
      rd_chk(8'he0, 32'h0000_0000);
   endtask
   task finish_test;
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      test_reset_values();
      test_state_writes();
      test_wake_reset();
      test_mid_reset();
      finish_test();
   end
endmodule
`default_nettype wire
